// ### verilog/ocdcs_pkg.sv
package ocdcs_pkg;
  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_CTL = 8'h04;
  localparam logic [7:0] CMD_RD_CTL = 8'h05;
  localparam logic [7:0] CMD_WR_REG = 8'h08;
  localparam logic [7:0] CMD_RD_REG = 8'h09;
  localparam logic [7:0] CMD_WR_PROG = 8'h0A;
  localparam logic [7:0] CMD_RD_PROG = 8'h0B;
  localparam logic [7:0] CMD_WR_DATA = 8'h0C;
  localparam logic [7:0] CMD_RD_DATA = 8'h0D;
  localparam logic [7:0] CMD_CRC = 8'h0E;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_STUFF = 8'h11;
  localparam logic [7:0] CMD_EXEC = 8'h12;

  // ----------------------------------------------------------------
  // debugger control register layout and fill values
  // ----------------------------------------------------------------
  localparam int CTL_HALT_BIT = 7;
  localparam int CTL_BRK_BIT = 6;
  localparam int CTL_ACK_BIT = 5;
  localparam int CTL_RST_BIT = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_STORE_MASK = 8'hE0;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [15:0] CRC_FILL = 16'hFFFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // ----------------------------------------------------------------
  // header lengths and transfer sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] HDR_REG_LEN = 3'h3;
  localparam logic [2:0] HDR_MEM_LEN = 3'h4;
  localparam logic [16:0] SIZE_REG_MAX = 17'h0_0100;
  localparam logic [16:0] SIZE_MEM_MAX = 17'h1_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPACE_REG, SPACE_PROG, SPACE_DATA} ocdcs_space_t;

  typedef struct packed {
    logic valid;
    logic write;
    ocdcs_space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ocdcs_mem_req_t;

  typedef struct packed {
    logic step;
    logic stuff;
    logic exec;
    logic exec_first;
    logic [7:0] opbyte;
  } ocdcs_cpu_cmd_t;
endpackage

// ### verilog/ocdcs_top.sv
// Notes on behaviour
// - register read: command, {0000,addr[11:8]}, addr[7:0], size; zero size is 256
// - register read gives FFH per byte outside debug or under read protection
// - program write: command, address hi/lo, size hi/lo, data; zero size 65536
// - program write data dropped unless flash unlocked, debug, and unprotected
// - program read framed like write; FFH outside debug or under protection
// - data write: address and size high first; dropped outside debug or protected
// - data read 1..65536 bytes; FFH only outside debug, protection ignored
// - CRC-CCITT over all program memory, high byte first; FFFFH outside debug
// - CRC answer comes only after every program byte has been read
// - step runs one instruction; ignored outside debug or under protection
// - stuff takes host opcode byte, rest fetched by CPU; ignored when blocked
// - execute takes 1..5 bytes sized by opcode; blocked case eats one byte
// - 81H resets and halts, 41H resets and runs, 40H resumes from debug
// - control: halt bit7, break enable bit6, ack enable bit5, reset bit0, zero reset
// - register write dropped outside debug; protected allows only flash registers
// - under protection a control write can set halt but never clear it
module ocdcs_top #(
  parameter int unsigned PROG_SIZE = 65536,
  parameter logic [11:0] FLASH_REG_FIRST = 12'hFF8,
  parameter logic [11:0] FLASH_REG_LAST = 12'hFFD
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // command bytes from the serial framer
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  // answer bytes to the serial framer
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // memory and register file access
  output ocdcs_pkg::ocdcs_mem_req_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  // cpu side
  output ocdcs_pkg::ocdcs_cpu_cmd_t cpu_cmd_o,
  input wire logic [2:0] instr_len_i,
  input wire logic break_hit_i,
  output logic debug_halt_o,
  output logic breakpoint_enable_o,
  output logic debug_ack_enable_o,
  output logic dev_reset_o,
  // protection status
  input wire logic read_protect_i,
  input wire logic flash_unlocked_i
);
  import ocdcs_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one byte of msb-first crc-ccitt
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // permission for a memory command at the given address
  function automatic logic mem_allowed(input logic [7:0] c, input logic dbg,
                                       input logic prot, input logic unl,
                                       input logic [15:0] a);
    logic r;
    r = 1'b0;
    unique case (c)
      CMD_WR_REG: r = dbg && (!prot || (a[11:0] >= FLASH_REG_FIRST &&
                                        a[11:0] <= FLASH_REG_LAST));
      CMD_RD_REG: r = dbg && !prot;
      CMD_WR_PROG: r = dbg && !prot && unl;
      CMD_RD_PROG: r = dbg && !prot;
      CMD_WR_DATA: r = dbg && !prot;
      CMD_RD_DATA: r = dbg;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic ocdcs_space_t space_of(input logic [7:0] c);
    ocdcs_space_t s;
    s = SPACE_DATA;
    if (c == CMD_WR_REG || c == CMD_RD_REG) begin
      s = SPACE_REG;
    end else if (c == CMD_WR_PROG || c == CMD_RD_PROG) begin
      s = SPACE_PROG;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // interpreter state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_CTLW, S_RD, S_RDW, S_TX, S_WR, S_WRW, S_CRC, S_CRCW, S_STUFF, S_EXEC
  } ocdcs_state_t;

  localparam logic [15:0] PROG_LAST = 16'(PROG_SIZE - 1);

  ocdcs_state_t st_q, st_d;
  logic [7:0] cmd_q, cmd_d;
  logic [2:0] hdr_q, hdr_d;
  logic [23:0] sh_q, sh_d;
  logic [15:0] addr_q, addr_d;
  logic [16:0] cnt_q, cnt_d;
  logic [7:0] tx_q, tx_d;
  logic [15:0] crc_q, crc_d;
  logic [7:0] ctl_q, ctl_d;
  ocdcs_mem_req_t mem_q, mem_d;
  ocdcs_cpu_cmd_t cpu_q, cpu_d;
  logic rst_q, rst_d;
  logic dbg, prot, ok, is_wr;
  logic [31:0] full;
  logic [15:0] crc_nx;

  assign dbg = ctl_q[CTL_HALT_BIT];
  assign prot = read_protect_i;
  assign ok = mem_allowed(cmd_q, dbg, prot, flash_unlocked_i, addr_q);
  assign is_wr = (cmd_q == CMD_WR_REG) || (cmd_q == CMD_WR_PROG) || (cmd_q == CMD_WR_DATA);
  assign full = {sh_q, rx_data_i};
  assign crc_nx = crc_byte(crc_q, mem_rdata_i);

  // bytes are taken only where the interpreter is waiting for one
  assign rx_ready_o = (st_q == S_IDLE) || (st_q == S_HDR) || (st_q == S_CTLW) ||
                      (st_q == S_WR) || (st_q == S_STUFF) || (st_q == S_EXEC);
  assign tx_valid_o = (st_q == S_TX);
  assign tx_data_o = tx_q;
  assign mem_req_o = mem_q;
  assign cpu_cmd_o = cpu_q;
  assign debug_halt_o = ctl_q[CTL_HALT_BIT];
  assign breakpoint_enable_o = ctl_q[CTL_BRK_BIT];
  assign debug_ack_enable_o = ctl_q[CTL_ACK_BIT];
  assign dev_reset_o = rst_q;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // the whole interpreter is one group so each byte sees one coherent view
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    hdr_d = hdr_q;
    sh_d = sh_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    crc_d = crc_q;
    ctl_d = ctl_q;
    mem_d = mem_q;
    cpu_d = '0;
    rst_d = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        if (rx_valid_i) begin
          cmd_d = rx_data_i;
          unique case (rx_data_i)
            CMD_WR_REG, CMD_RD_REG: begin
              hdr_d = HDR_REG_LEN;
              st_d = S_HDR;
            end
            CMD_WR_PROG, CMD_RD_PROG, CMD_WR_DATA, CMD_RD_DATA: begin
              hdr_d = HDR_MEM_LEN;
              st_d = S_HDR;
            end
            CMD_WR_CTL: st_d = S_CTLW;
            CMD_RD_CTL: begin
              tx_d = ctl_q;
              cnt_d = 17'h0_0001;
              st_d = S_TX;
            end
            CMD_CRC: begin
              if (dbg) begin
                addr_d = 16'h0000;
                crc_d = CRC_INIT;
                st_d = S_CRC;
              end else begin
                crc_d = CRC_FILL;
                tx_d = CRC_FILL[15:8];
                cnt_d = 17'h0_0002;
                st_d = S_TX;
              end
            end
            CMD_STEP: cpu_d.step = dbg && !prot;
            CMD_STUFF: st_d = S_STUFF;
            CMD_EXEC: begin
              cnt_d = 17'h0_0000;
              st_d = S_EXEC;
            end
            default: st_d = S_IDLE;
          endcase
        end
      end
      S_HDR: begin
        if (rx_valid_i) begin
          sh_d = full[23:0];
          hdr_d = hdr_q - 3'h1;
          if (hdr_q == 3'h1) begin
            if (space_of(cmd_q) == SPACE_REG) begin
              addr_d = {4'h0, full[19:8]};
              cnt_d = (full[7:0] == 8'h00) ? SIZE_REG_MAX : {9'h000, full[7:0]};
            end else begin
              addr_d = full[31:16];
              cnt_d = (full[15:0] == 16'h0000) ? SIZE_MEM_MAX : {1'b0, full[15:0]};
            end
            st_d = is_wr ? S_WR : S_RD;
          end
        end
      end
      S_CTLW: begin
        if (rx_valid_i) begin
          ctl_d = rx_data_i & CTL_STORE_MASK;
          if (prot && ctl_q[CTL_HALT_BIT]) begin
            ctl_d[CTL_HALT_BIT] = 1'b1;
          end
          if (break_hit_i && ctl_q[CTL_BRK_BIT]) begin
            ctl_d[CTL_HALT_BIT] = 1'b1;
          end
          rst_d = rx_data_i[CTL_RST_BIT];
          st_d = S_IDLE;
        end
      end
      S_RD: begin
        if (ok) begin
          mem_d = '{valid: 1'b1, write: 1'b0, space: space_of(cmd_q), addr: addr_q,
                    wdata: 8'h00};
          st_d = S_RDW;
        end else begin
          tx_d = FILL_BYTE;
          st_d = S_TX;
        end
      end
      S_RDW: begin
        if (mem_ack_i) begin
          mem_d.valid = 1'b0;
          tx_d = mem_rdata_i;
          st_d = S_TX;
        end
      end
      S_TX: begin
        if (tx_ready_i) begin
          cnt_d = cnt_q - 17'h0_0001;
          addr_d = addr_q + 16'h0001;
          if (cnt_q == 17'h0_0001) begin
            st_d = S_IDLE;
          end else if (cmd_q == CMD_CRC) begin
            tx_d = crc_q[7:0];
          end else begin
            st_d = S_RD;
          end
        end
      end
      S_WR: begin
        if (rx_valid_i) begin
          cnt_d = cnt_q - 17'h0_0001;
          if (ok) begin
            mem_d = '{valid: 1'b1, write: 1'b1, space: space_of(cmd_q), addr: addr_q,
                      wdata: rx_data_i};
            st_d = S_WRW;
          end else begin
            addr_d = addr_q + 16'h0001; // dropped byte still advances
            if (cnt_q == 17'h0_0001) begin
              st_d = S_IDLE;
            end
          end
        end
      end
      S_WRW: begin
        if (mem_ack_i) begin
          mem_d.valid = 1'b0;
          addr_d = addr_q + 16'h0001;
          st_d = (cnt_q == 17'h0_0000) ? S_IDLE : S_WR;
        end
      end
      S_CRC: begin
        mem_d = '{valid: 1'b1, write: 1'b0, space: SPACE_PROG, addr: addr_q, wdata: 8'h00};
        st_d = S_CRCW;
      end
      S_CRCW: begin
        if (mem_ack_i) begin
          mem_d.valid = 1'b0;
          crc_d = crc_nx;
          addr_d = addr_q + 16'h0001;
          if (addr_q == PROG_LAST) begin
            tx_d = crc_nx[15:8];
            cnt_d = 17'h0_0002;
            st_d = S_TX;
          end else begin
            st_d = S_CRC;
          end
        end
      end
      S_STUFF: begin
        if (rx_valid_i) begin
          cpu_d.stuff = dbg && !prot;
          cpu_d.opbyte = rx_data_i;
          st_d = S_IDLE;
        end
      end
      S_EXEC: begin
        if (rx_valid_i) begin
          if (!(dbg && !prot)) begin
            st_d = S_IDLE;
          end else begin
            cpu_d.exec = 1'b1;
            cpu_d.opbyte = rx_data_i;
            if (cnt_q == 17'h0_0000) begin
              cpu_d.exec_first = 1'b1;
              cnt_d = {14'h0000, instr_len_i} - 17'h0_0001;
              if (instr_len_i <= 3'h1) begin
                st_d = S_IDLE;
              end
            end else begin
              cnt_d = cnt_q - 17'h0_0001;
              if (cnt_q == 17'h0_0001) begin
                st_d = S_IDLE;
              end
            end
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    // a break seen by the cpu halts it; this set beats any clear
    if (break_hit_i && ctl_q[CTL_BRK_BIT]) begin
      ctl_d[CTL_HALT_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= S_IDLE;
      cmd_q <= 8'h00;
      hdr_q <= 3'h0;
      sh_q <= 24'h00_0000;
      addr_q <= 16'h0000;
      cnt_q <= 17'h0_0000;
      tx_q <= 8'h00;
      crc_q <= 16'h0000;
      ctl_q <= CTL_RESET;
      mem_q <= '0;
      cpu_q <= '0;
      rst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      hdr_q <= hdr_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      crc_q <= crc_d;
      ctl_q <= ctl_d;
      mem_q <= mem_d;
      cpu_q <= cpu_d;
      rst_q <= rst_d;
    end
  end
endmodule

// ### test/ocdcs_assertions.sv
module ocdcs_assertions
  import ocdcs_pkg::*;
#(
  parameter logic [11:0] FLASH_REG_FIRST = 12'hFF8,
  parameter logic [11:0] FLASH_REG_LAST = 12'hFFD
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched ports
  input wire logic tx_valid_o,
  input wire ocdcs_pkg::ocdcs_mem_req_t mem_req_o,
  input wire ocdcs_pkg::ocdcs_cpu_cmd_t cpu_cmd_o,
  input wire logic break_hit_i,
  input wire logic debug_halt_o,
  input wire logic breakpoint_enable_o,
  input wire logic dev_reset_o,
  input wire logic read_protect_i,
  input wire logic flash_unlocked_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // gating of side effects by mode and protection
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic wr_q, rd_q, fl_q;
  // decoded request kinds, kept apart so each property stays short
  assign wr_q = mem_req_o.valid && mem_req_o.write;
  assign rd_q = mem_req_o.valid && !mem_req_o.write;
  assign fl_q = mem_req_o.addr[11:0] >= FLASH_REG_FIRST && mem_req_o.addr[11:0] <= FLASH_REG_LAST;

  a_reset_idle: assert property (disable iff (1'b0) reset_i |=>
    !tx_valid_o && !mem_req_o.valid && !debug_halt_o && !dev_reset_o) else $error("not idle");
  a_halt_kept_prot: assert property (debug_halt_o && read_protect_i |=> debug_halt_o)
    else $error("halt cleared under protection");
  a_break_sets_halt: assert property (break_hit_i && breakpoint_enable_o |=> debug_halt_o)
    else $error("break did not halt");
  a_step_gated: assert property (cpu_cmd_o.step |-> $past(debug_halt_o) && !$past(read_protect_i))
    else $error("step while blocked");
  a_cpu_cmd_gated: assert property ((cpu_cmd_o.stuff || cpu_cmd_o.exec) |->
    $past(debug_halt_o) && !$past(read_protect_i)) else $error("instruction while blocked");
  a_prog_wr_gated: assert property (wr_q && mem_req_o.space == SPACE_PROG |->
    debug_halt_o && !read_protect_i && flash_unlocked_i) else $error("program write leaked");
  a_data_wr_gated: assert property (wr_q && mem_req_o.space == SPACE_DATA |->
    debug_halt_o && !read_protect_i) else $error("data write leaked");
  a_reg_wr_gated: assert property (wr_q && mem_req_o.space == SPACE_REG |->
    debug_halt_o && (!read_protect_i || fl_q)) else $error("register write leaked");
  a_reg_rd_gated: assert property (rd_q && mem_req_o.space == SPACE_REG |->
    debug_halt_o && !read_protect_i) else $error("register read leaked");
endmodule

bind ocdcs_top ocdcs_assertions #(.FLASH_REG_FIRST(FLASH_REG_FIRST),
  .FLASH_REG_LAST(FLASH_REG_LAST)) u_ocdcs_assertions (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .tx_valid_o(tx_valid_o),
  .mem_req_o(mem_req_o),
  .cpu_cmd_o(cpu_cmd_o),
  .break_hit_i(break_hit_i),
  .debug_halt_o(debug_halt_o),
  .breakpoint_enable_o(breakpoint_enable_o),
  .dev_reset_o(dev_reset_o),
  .read_protect_i(read_protect_i),
  .flash_unlocked_i(flash_unlocked_i)
);

// ### test/ocdcs_mem_model.sv
module ocdcs_mem_model
  import ocdcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // request in, answer out
  input wire ocdcs_pkg::ocdcs_mem_req_t mem_req_o,
  output logic mem_ack_i = 1'b0,
  output logic [7:0] mem_rdata_i = 8'h00,
  output int mem_wr_count = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [3][65536];
  logic [1:0] wait_q = 2'h0;
  logic slow_q = 1'b0;
  // alternate prompt and slow answers; read data flips outside acks so nothing stale passes
  always @(posedge clk_i) begin
    mem_ack_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i;
    if (reset_i) begin
      wait_q <= 2'h0;
    end else if (mem_req_o.valid && !mem_ack_i) begin
      if (wait_q == {slow_q, slow_q}) begin
        mem_ack_i <= 1'b1;
        wait_q <= 2'h0;
        slow_q <= ~slow_q;
        if (mem_req_o.write) begin
          mem_q[int'(mem_req_o.space)][mem_req_o.addr] <= mem_req_o.wdata;
          mem_wr_count <= mem_wr_count + 1;
        end else begin
          mem_rdata_i <= mem_q[int'(mem_req_o.space)][mem_req_o.addr];
        end
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// ### test/ocdcs_top_tb.sv
module ocdcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ocdcs_pkg::*;
  logic clk_i = 0, reset_i = 1, rx_valid_i = 0, tx_ready_i = 0, break_hit_i = 0;
  logic read_protect_i = 0, flash_unlocked_i = 0;
  logic [7:0] rx_data_i = 8'h00;
  logic [2:0] instr_len_i = 3'h1;
  logic rx_ready_o, tx_valid_o, mem_ack_i, debug_halt_o, breakpoint_enable_o;
  logic debug_ack_enable_o, dev_reset_o;
  logic [7:0] tx_data_o, mem_rdata_i, last_op, b, buf_q[16];
  ocdcs_mem_req_t mem_req_o;
  ocdcs_cpu_cmd_t cpu_cmd_o;
  int errors = 0, total_checks = 0, cyc = 0, mem_wr_count, t, len;
  int n_step = 0, n_stuff = 0, n_exec = 0, n_first = 0, n_rst = 0;
  logic [15:0] a;
  logic [2:0] pins;
  logic [7:0] wcmd[3] = '{CMD_WR_REG, CMD_WR_PROG, CMD_WR_DATA};
  logic [7:0] rcmd[3] = '{CMD_RD_REG, CMD_RD_PROG, CMD_RD_DATA};
  logic [7:0] codes[4] = '{8'hFF, 8'h41, 8'h40, 8'h81};

  ocdcs_top #(.PROG_SIZE(16)) u_ocdcs_top (.*);
  ocdcs_mem_model u_ocdcs_mem_model (.*);

  // ------------------------------------------------------------
  // clock, pulse counters and hang limit
  // ------------------------------------------------------------
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cpu_cmd_o.step === 1'b1) n_step++;
    if (cpu_cmd_o.exec === 1'b1) n_exec++;
    if (cpu_cmd_o.exec_first === 1'b1) n_first++;
    if (dev_reset_o === 1'b1) n_rst++;
    if (cpu_cmd_o.stuff === 1'b1) begin
      n_stuff++;
      last_op = cpu_cmd_o.opbyte;
    end
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // host side tasks and expectations
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask
  // request held from a falling edge until the rising edge that sees ready
  task automatic send(input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    rx_valid_i = 1;
    rx_data_i = d;
    while (rx_ready_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000) chk(16'h0000, 16'h0001, "rx hang");
    @(negedge clk_i);
    rx_valid_i = 0;
  endtask
  // one edge always passes first so tx_ready_i is never set twice in one step
  task automatic get(input logic [7:0] e, input string m);
    int n;
    n = 0;
    @(negedge clk_i);
    while (tx_valid_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000) chk(16'h0000, 16'h0001, "tx hang");
    chk(16'(tx_data_o), 16'(e), m);
    tx_ready_i = 1;
    @(negedge clk_i);
    tx_ready_i = 0;
  endtask
  task automatic hdr(input logic [7:0] c, input logic [15:0] ad, input logic [15:0] sz);
    send(c);
    if (c == CMD_WR_REG || c == CMD_RD_REG) send({4'h0, ad[11:8]});
    else send(ad[15:8]);
    send(ad[7:0]);
    if (c != CMD_WR_REG && c != CMD_RD_REG) send(sz[15:8]);
    send(sz[7:0]);
  endtask
  task automatic ctl(input logic [7:0] v);
    send(CMD_WR_CTL);
    send(v);
  endtask
  task automatic ctl_rd(input logic [7:0] e, input string m);
    send(CMD_RD_CTL);
    get(e, m);
  endtask
  // settle pending requests before the protection inputs move
  task automatic mode(input int p, input int u);
    repeat (8) @(negedge clk_i);
    read_protect_i = p[0];
    flash_unlocked_i = u[0];
  endtask
  function automatic logic [7:0] rd_exp(input int s, input logic p, input logic [7:0] d);
    return (p && s != 2) ? FILL_BYTE : d;
  endfunction
  function automatic logic [15:0] crc16(input logic [7:0] d[16]);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      c ^= {d[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  initial begin
    void'($urandom(32'h63075cb7));
    repeat (3) @(negedge clk_i);
    reset_i = 0;
    ctl_rd(CTL_RESET, "ctl reset");
    for (int i = 0; i < 4; i++) begin
      t = n_rst;
      ctl(codes[i]);
      ctl_rd(codes[i] & CTL_STORE_MASK, "ctl write");
      chk(16'(n_rst - t), 16'(codes[i][0]), "reset pulse");
      pins = {debug_halt_o, breakpoint_enable_o, debug_ack_enable_o};
      chk(16'(pins), 16'(codes[i][7:5]), "ctl pins");
    end
    ctl(8'h40);
    ctl_rd(8'h40, "resume");
    @(negedge clk_i);
    break_hit_i = 1;
    @(negedge clk_i);
    break_hit_i = 0;
    ctl_rd(8'hC0, "break halt");
    $display("test control done");
    for (int s = 0; s < 3; s++) begin
      a = 16'($urandom()) & ((s == 0) ? 16'h07FF : 16'hFFFF);
      mode(0, 1);
      hdr(wcmd[s], a, 16'h0003);
      for (int k = 0; k < 3; k++) begin
        buf_q[k] = 8'($urandom());
        send(buf_q[k]);
      end
      for (int p = 0; p < 2; p++) begin
        mode(p[0], 1);
        hdr(rcmd[s], a, 16'h0003);
        for (int k = 0; k < 3; k++) get(rd_exp(s, p[0], buf_q[k]), "read");
      end
      t = mem_wr_count;
      hdr(wcmd[s], a, 16'h0001);
      send(8'h5A);
      mode(1, 0);
      chk(16'(mem_wr_count - t), 16'h0000, "protected write");
    end
    t = mem_wr_count;
    hdr(CMD_WR_REG, 16'h0FF8, 16'h0001);
    send(8'h33);
    mode(0, 0);
    hdr(CMD_WR_PROG, a, 16'h0001);
    send(8'h44);
    mode(0, 1);
    chk(16'(mem_wr_count - t), 16'h0001, "flash reg and locked");
    hdr(CMD_WR_PROG, 16'h0000, 16'h0010);
    for (int k = 0; k < 16; k++) begin
      buf_q[k] = 8'($urandom());
      send(buf_q[k]);
    end
    send(CMD_CRC);
    t = cyc;
    get(8'(crc16(buf_q) >> 8), "crc high");
    chk(16'(cyc - t >= 16), 16'h0001, "crc delay");
    get(8'(crc16(buf_q)), "crc low");
    $display("test memory done");
    {n_step, n_stuff, n_exec, n_first} = '0;
    len = $urandom_range(5, 1);
    instr_len_i = 3'(len);
    b = 8'($urandom());
    send(CMD_STEP);
    send(CMD_STUFF);
    send(b);
    send(CMD_EXEC);
    repeat (len) send(8'($urandom()));
    ctl_rd(8'hC0, "after cpu");
    chk(16'(n_step), 16'h0001, "step");
    chk(16'(n_stuff), 16'h0001, "stuff");
    chk(16'(last_op), 16'(b), "stuff opcode");
    chk(16'(n_exec), 16'(len), "exec bytes");
    chk(16'(n_first), 16'h0001, "exec first");
    mode(1, 0);
    send(CMD_STEP);
    send(CMD_STUFF);
    send(b);
    send(CMD_EXEC);
    send(CMD_RD_CTL);
    ctl(8'h00);
    ctl_rd(8'h80, "protected halt");
    chk(16'(n_step + n_stuff + n_exec - len - 2), 16'h0000, "blocked cpu");
    $display("test cpu done");
    mode(0, 1);
    reset_i = 1;
    repeat (2) @(negedge clk_i);
    reset_i = 0;
    hdr(CMD_RD_REG, 16'h0000, 16'h0000);
    repeat (256) get(FILL_BYTE, "size zero");
    hdr(CMD_RD_DATA, a, 16'h0001);
    get(FILL_BYTE, "data outside");
    send(CMD_CRC);
    get(8'hFF, "crc outside");
    get(8'hFF, "crc outside");
    for (int i = 0; i < 4; i++) begin
      send((i == 0) ? 8'h0F : 8'($urandom_range(255, 19)));
      ctl_rd(CTL_RESET, "unknown command");
    end
    $display("test outside done");
    stop_test();
  end
endmodule
